// ### bsf_pkg.sv
// Package of constants for the buck start-up and fault sequencer
package bsf_pkg;
   // ****************************************
   // Clock and timing
   // ****************************************
   localparam int CLK_HZ = 10_000_000;
   localparam int SW_FREQ_HZ = 300_000;
   localparam int SW_PERIOD_CYC = CLK_HZ / SW_FREQ_HZ;
   localparam int DET_FREQ_HZ = 60_000;
   localparam int DET_PERIOD_CYC = CLK_HZ / DET_FREQ_HZ;
   localparam int DET_PULSE_NS = 200;
   localparam int DET_PULSE_CYC = (DET_PULSE_NS * (CLK_HZ / 1_000_000)
      + 999) / 1000;
   localparam int DEAD_NS = 100;
   localparam int DEAD_CYC = (DEAD_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
   localparam int CAPTURE_US = 50;
   localparam int CAPTURE_CYC = CAPTURE_US * (CLK_HZ / 1_000_000);
   localparam int SAMPLE_NS = 200;
   localparam int SAMPLE_CYC = (SAMPLE_NS * (CLK_HZ / 1_000_000) + 999)
      / 1000;
   localparam int HICCUP_US = 2_000;
   localparam int HICCUP_CYC = HICCUP_US * (CLK_HZ / 1_000_000);
   localparam int SS_STEP_CYC = 4;

   // ****************************************
   // Levels, codes of the 10-bit converters
   // ****************************************
   localparam int LVL_W = 10;
   localparam logic [9:0] DEFAULT_TRIP = 10'h0_0BC;
   localparam logic [9:0] TRIP_BUILD_MIN = 10'h0_008;
   localparam logic [9:0] REF_CODE = 10'h0_200;
   localparam logic [9:0] UV_CODE = 10'h0_180;

   // ****************************************
   // Sequencer states
   // ****************************************
   typedef enum logic [2:0] {
      BSF_OFF = 3'b000,
      BSF_CAPTURE = 3'b001,
      BSF_DETECT = 3'b010,
      BSF_SOFTSTART = 3'b011,
      BSF_RUN = 3'b100,
      BSF_HICCUP = 3'b101
   } bsf_state_t;
endpackage

// ### bsf_gate_ctl.sv
// Dead-time interlock for the two gate commands
`timescale 1ns/10ps
module bsf_gate_ctl (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_hs_req,
   input wire logic i_ls_req,
   output logic o_high_side_gate,
   output logic o_low_side_gate
);
   logic hs_reg, hs_next, ls_reg, ls_next;
   logic [3:0] dead_reg, dead_next;

   always_comb begin
      hs_next = hs_reg;
      ls_next = ls_reg;
      dead_next = (dead_reg != 4'h0) ? dead_reg - 4'h1 : 4'h0;
      if (!i_hs_req) begin
         hs_next = 1'b0;
      end
      if (!i_ls_req) begin
         ls_next = 1'b0;
      end
      if (hs_reg && !hs_next || ls_reg && !ls_next) begin
         dead_next = 4'(bsf_pkg::DEAD_CYC); // R14
      end
      if (dead_reg == 4'h0 && !hs_reg && !ls_reg && hs_next == 1'b0
          && ls_next == 1'b0) begin
         if (i_hs_req && !i_ls_req) begin
            hs_next = 1'b1; // R14
         end else if (i_ls_req && !i_hs_req) begin
            ls_next = 1'b1; // R14
         end
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         hs_reg <= 1'b0;
         ls_reg <= 1'b0;
         dead_reg <= 4'h0;
      end else begin
         hs_reg <= hs_next;
         ls_reg <= ls_next;
         dead_reg <= dead_next;
      end
   end

   assign o_high_side_gate = hs_reg;
   assign o_low_side_gate = ls_reg;

   property p_no_overlap;
      @(posedge i_clk) disable iff (!i_rst_n) !(hs_reg && ls_reg);
   endproperty
   a_no_overlap: assert property (p_no_overlap) // R14
      else $error("both gates on");

   property p_dead_gap;
      @(posedge i_clk) disable iff (!i_rst_n)
         $fell(ls_reg) |-> !hs_reg [*2];
   endproperty
   a_dead_gap: assert property (p_dead_gap) // R14
      else $error("no dead time after low side");
endmodule

// ### bsf_sequencer.sv
// Start-up, enable and fault sequencer of the buck controller
`timescale 1ns/10ps
// Behaviour
// R1: POR rise resets and restarts sequencing
// R2: POR fall stops all switching
// R3: Enable low shuts down, gates low
// R4: Enable return restarts init and soft-start
// R5: Detect pulses 200ns at 60kHz, low off
// R6: Phase above 1V on pulse starts soft-start
// R7: Soft-start ramps target uniformly when enabled
// R8: Ramp past reference hands over to reference
// R9: Drive set current, store trip, stop current
// R10: No voltage built means default trip level
// R11: Sample phase early in low-side interval
// R12: Sample below trip gives overcurrent hiccup
// R13: Feedback under 75% gives undervoltage hiccup
// R14: Dead time, never both gates on
// R15: Fixed internal switching oscillator pacing
// R16: Hiccup waits gates off, reruns soft-start
module bsf_sequencer #(
   parameter int HICCUP_CYC = bsf_pkg::HICCUP_CYC
) (
   input wire logic i_clk,
   input wire logic i_nrst,
   input wire logic i_supply_ok,
   input wire logic i_enable_level,
   input wire logic i_phase_above_1v,
   input wire logic [9:0] i_phase_level,
   input wire logic [9:0] i_gate_pin_level,
   input wire logic [9:0] i_feedback_input,
   input wire logic [9:0] i_duty_cmd,
   output logic o_high_side_gate,
   output logic o_low_side_gate,
   output logic o_threshold_set_current,
   output logic [9:0] o_target,
   output logic [9:0] o_stored_trip_level,
   output logic o_overcurrent_trip,
   output logic o_undervoltage_trip,
   output logic o_softstart_done
);
   // ****************************************
   // Reset release
   // ****************************************
   logic rst_a_reg, rst_n;
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         rst_a_reg <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_a_reg <= 1'b1;
         rst_n <= rst_a_reg;
      end
   end

   // ****************************************
   // Oscillator
   // ****************************************
   logic [5:0] osc_reg, osc_next;
   logic [7:0] det_reg, det_next;
   bsf_pkg::bsf_state_t state_reg, state_next;
   always_comb begin
      osc_next = (osc_reg == 6'(bsf_pkg::SW_PERIOD_CYC - 1)) ? 6'h00
         : osc_reg + 6'h01; // R15
      // Detect pacing restarts on entry so the first pulse is full width
      det_next = (state_reg != bsf_pkg::BSF_DETECT
         || det_reg == 8'(bsf_pkg::DET_PERIOD_CYC - 1)) ? 8'h00
         : det_reg + 8'h01; // R5
   end

   // ****************************************
   // Sequencer
   // ****************************************
   logic [15:0] cnt_reg, cnt_next;
   logic [9:0] trip_reg, trip_next;
   logic [9:0] ss_reg, ss_next;
   logic [9:0] samp_reg, samp_next;
   logic ocp_reg, ocp_next, uvp_reg, uvp_next, done_reg, done_next;
   logic hs_req, ls_req, hs_g, ls_g, go;

   assign go = i_supply_ok && i_enable_level;

   always_comb begin
      state_next = state_reg;
      cnt_next = cnt_reg;
      trip_next = trip_reg;
      ss_next = ss_reg;
      samp_next = samp_reg;
      ocp_next = ocp_reg;
      uvp_next = uvp_reg;
      done_next = done_reg;
      case (state_reg)
         bsf_pkg::BSF_OFF: begin
            cnt_next = 16'h0000;
            ss_next = 10'h000;
            done_next = 1'b0;
            if (go) begin
               state_next = bsf_pkg::BSF_CAPTURE; // R1 R4
            end
         end
         bsf_pkg::BSF_CAPTURE: begin
            cnt_next = cnt_reg + 16'h0001;
            if (cnt_reg == 16'(bsf_pkg::CAPTURE_CYC - 1)) begin
               cnt_next = 16'h0000;
               if (i_gate_pin_level < bsf_pkg::TRIP_BUILD_MIN) begin
                  trip_next = bsf_pkg::DEFAULT_TRIP; // R10
               end else begin
                  trip_next = i_gate_pin_level; // R9
               end
               state_next = bsf_pkg::BSF_DETECT;
            end
         end
         bsf_pkg::BSF_DETECT: begin
            if (hs_g && i_phase_above_1v) begin
               state_next = bsf_pkg::BSF_SOFTSTART; // R6
            end
         end
         bsf_pkg::BSF_SOFTSTART: begin
            cnt_next = cnt_reg + 16'h0001;
            if (cnt_reg == 16'(bsf_pkg::SS_STEP_CYC - 1)) begin
               cnt_next = 16'h0000;
               ss_next = ss_reg + 10'h001; // R7
            end
            if (ss_reg > bsf_pkg::REF_CODE) begin
               state_next = bsf_pkg::BSF_RUN; // R8
               done_next = 1'b1;
               cnt_next = 16'h0000;
            end
         end
         bsf_pkg::BSF_RUN: begin
            // Count from low-side turn-on, so the sample lands early in it
            cnt_next = ls_g ? cnt_reg + 16'h0001 : 16'h0000;
            if (ls_g && cnt_reg == 16'(bsf_pkg::SAMPLE_CYC)) begin
               samp_next = i_phase_level; // R11
               if (i_phase_level < trip_reg) begin
                  ocp_next = 1'b1; // R12
               end
            end
            if (i_feedback_input < bsf_pkg::UV_CODE) begin
               uvp_next = 1'b1; // R13
            end
            if (ocp_next || uvp_next) begin
               state_next = bsf_pkg::BSF_HICCUP;
               cnt_next = 16'h0000;
               done_next = 1'b0;
            end
         end
         bsf_pkg::BSF_HICCUP: begin
            cnt_next = cnt_reg + 16'h0001;
            if (cnt_reg == 16'(HICCUP_CYC - 1)) begin
               cnt_next = 16'h0000;
               ss_next = 10'h000;
               ocp_next = 1'b0;
               uvp_next = 1'b0;
               state_next = bsf_pkg::BSF_SOFTSTART; // R16
            end
         end
         default: state_next = bsf_pkg::BSF_OFF;
      endcase
      if (!go) begin
         state_next = bsf_pkg::BSF_OFF; // R2 R3
         ocp_next = 1'b0;
         uvp_next = 1'b0;
      end
   end

   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_reg <= bsf_pkg::BSF_OFF;
         cnt_reg <= 16'h0000;
         trip_reg <= bsf_pkg::DEFAULT_TRIP;
         ss_reg <= 10'h000;
         samp_reg <= 10'h000;
         ocp_reg <= 1'b0;
         uvp_reg <= 1'b0;
         done_reg <= 1'b0;
         osc_reg <= 6'h00;
         det_reg <= 8'h00;
      end else begin
         state_reg <= state_next;
         cnt_reg <= cnt_next;
         trip_reg <= trip_next;
         ss_reg <= ss_next;
         samp_reg <= samp_next;
         ocp_reg <= ocp_next;
         uvp_reg <= uvp_next;
         done_reg <= done_next;
         osc_reg <= osc_next;
         det_reg <= det_next;
      end
   end

   // ****************************************
   // Gate requests
   // ****************************************
   logic [9:0] duty_lim;
   always_comb begin
      hs_req = 1'b0;
      ls_req = 1'b0;
      duty_lim = (state_reg == bsf_pkg::BSF_SOFTSTART
         && i_duty_cmd > ss_reg) ? ss_reg : i_duty_cmd;
      case (state_reg)
         bsf_pkg::BSF_DETECT: begin
            hs_req = (det_reg < 8'(bsf_pkg::DET_PULSE_CYC)); // R5
         end
         bsf_pkg::BSF_SOFTSTART, bsf_pkg::BSF_RUN: begin
            hs_req = ({4'h0, osc_reg} < duty_lim[9:4]
               && duty_lim[9:4] != 6'h00);
            ls_req = !hs_req;
         end
         default: begin
            hs_req = 1'b0; // R12 R13 R16
            ls_req = 1'b0;
         end
      endcase
   end

   bsf_gate_ctl u_gate (
      .i_clk(i_clk),
      .i_rst_n(rst_n),
      .i_hs_req(hs_req),
      .i_ls_req(ls_req),
      .o_high_side_gate(hs_g),
      .o_low_side_gate(ls_g)
   );

   assign o_high_side_gate = hs_g;
   assign o_low_side_gate = ls_g;
   assign o_threshold_set_current = (state_reg == bsf_pkg::BSF_CAPTURE);
   assign o_target = done_reg ? bsf_pkg::REF_CODE : ss_reg; // R8
   assign o_stored_trip_level = trip_reg;
   assign o_overcurrent_trip = ocp_reg;
   assign o_undervoltage_trip = uvp_reg;
   assign o_softstart_done = done_reg;

   // ****************************************
   // Checks
   // ****************************************
   property p_off_gates;
      @(posedge i_clk) disable iff (!rst_n)
         !go ##1 !go |-> ##1 !hs_g && !ls_g;
   endproperty
   a_off_gates: assert property (p_off_gates) // R3
      else $error("gates active while disabled");

   property p_supply_stop;
      @(posedge i_clk) disable iff (!rst_n)
         $fell(i_supply_ok) |=> state_reg == bsf_pkg::BSF_OFF;
   endproperty
   a_supply_stop: assert property (p_supply_stop) // R2
      else $error("no stop on supply loss");

   property p_start;
      @(posedge i_clk) disable iff (!rst_n)
         state_reg == bsf_pkg::BSF_OFF && go
         |=> state_reg == bsf_pkg::BSF_CAPTURE;
   endproperty
   a_start: assert property (p_start) // R1
      else $error("no capture after start");

   property p_detect_low;
      @(posedge i_clk) disable iff (!rst_n)
         state_reg == bsf_pkg::BSF_DETECT |-> !ls_req;
   endproperty
   a_detect_low: assert property (p_detect_low) // R5
      else $error("low side on during detect");

   property p_detect_exit;
      @(posedge i_clk) disable iff (!rst_n)
         state_reg == bsf_pkg::BSF_DETECT && hs_g && i_phase_above_1v && go
         |=> state_reg == bsf_pkg::BSF_SOFTSTART;
   endproperty
   a_detect_exit: assert property (p_detect_exit) // R6
      else $error("no soft-start after input detect");

   property p_default_trip;
      @(posedge i_clk) disable iff (!rst_n)
         state_reg == bsf_pkg::BSF_CAPTURE && state_next ==
         bsf_pkg::BSF_DETECT && i_gate_pin_level < bsf_pkg::TRIP_BUILD_MIN
         |=> trip_reg == bsf_pkg::DEFAULT_TRIP;
   endproperty
   a_default_trip: assert property (p_default_trip) // R10
      else $error("default trip not used");

   sequence s_fault;
      state_reg == bsf_pkg::BSF_RUN && state_next == bsf_pkg::BSF_HICCUP;
   endsequence
   property p_hiccup;
      @(posedge i_clk) disable iff (!rst_n)
         s_fault ##1 go |-> ##1 (state_reg == bsf_pkg::BSF_HICCUP
         && !hs_req && !ls_req);
   endproperty
   a_hiccup: assert property (p_hiccup) // R12 R16
      else $error("fault did not enter hiccup");

   property p_uv;
      @(posedge i_clk) disable iff (!rst_n)
         state_reg == bsf_pkg::BSF_RUN && go
         && i_feedback_input < bsf_pkg::UV_CODE |=> uvp_reg;
   endproperty
   a_uv: assert property (p_uv) // R13
      else $error("undervoltage missed");

   property p_sample_hold;
      @(posedge i_clk) disable iff (!rst_n)
         state_reg == bsf_pkg::BSF_RUN && ls_g
         && cnt_reg == 16'(bsf_pkg::SAMPLE_CYC)
         |=> samp_reg == $past(i_phase_level);
   endproperty
   a_sample_hold: assert property (p_sample_hold) // R11
      else $error("valley sample not held");
endmodule

// ### bsf_mosfet_model.sv
// Behavioural model of the external high-side and low-side switches
`timescale 1ns/10ps
module bsf_mosfet_model (
   input wire logic i_high_side_gate,
   input wire logic i_low_side_gate,
   input wire logic i_vin_present,
   input wire logic [9:0] i_valley_level,
   output logic o_phase_above_1v,
   output logic [9:0] o_phase_level
);
   // ****************************************
   // Switch node
   // ****************************************
   always_comb begin
      o_phase_above_1v = i_high_side_gate & i_vin_present;
      if (i_high_side_gate) begin
         o_phase_level = i_vin_present ? 10'h3FF : 10'h000;
      end else if (i_low_side_gate) begin
         o_phase_level = i_valley_level;
      end else begin
         // Body diode freewheel holds the node low
         o_phase_level = 10'h000;
      end
   end
endmodule

// ### bsf_sequencer_bench.sv
// Self-checking bench of the buck start-up and fault sequencer
`timescale 1ns/10ps
module bsf_sequencer_bench;
   localparam int HC = 50;
   logic i_clk = 1'b0;
   logic i_nrst = 1'b0;
   logic sup = 1'b0;
   logic en = 1'b0;
   logic vin = 1'b0;
   logic [9:0] gpl = 10'h000;
   logic [9:0] fb = 10'h200;
   logic [9:0] valley = 10'h300;
   logic p1v, hs, ls, cur, uvt, oct, ssd;
   logic prev_hs = 1'b0;
   logic prev_ls = 1'b0;
   logic [9:0] pl, tgt, trip, t1;
   int error_cnt = 0;
   int samples_checked = 0;
   int cyc = 0;
   int n, w, p;
   wire logic [4:0] obs = {ssd, oct, uvt, cur, hs};

   always #50 i_clk = ~i_clk;

   bsf_sequencer #(.HICCUP_CYC(HC)) DUT (.i_clk(i_clk), .i_nrst(i_nrst),
      .i_supply_ok(sup), .i_enable_level(en), .i_phase_above_1v(p1v),
      .i_phase_level(pl), .i_gate_pin_level(gpl), .i_feedback_input(fb),
      .i_duty_cmd(10'h100), .o_high_side_gate(hs), .o_low_side_gate(ls),
      .o_threshold_set_current(cur), .o_target(tgt),
      .o_stored_trip_level(trip), .o_overcurrent_trip(oct),
      .o_undervoltage_trip(uvt), .o_softstart_done(ssd));

   bsf_mosfet_model fets (.i_high_side_gate(hs), .i_low_side_gate(ls),
      .i_vin_present(vin), .i_valley_level(valley),
      .o_phase_above_1v(p1v), .o_phase_level(pl));

   // ****************************************
   // Shared tasks
   // ****************************************
   task automatic check(input logic [9:0] got, input logic [9:0] exp);
      samples_checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // Waits until one observed output shows lvl, counting cycles
   task automatic wait_on(input int b, input logic lvl, output int k);
      k = 0;
      while (obs[b] !== lvl && k < 3000) begin
         @(negedge i_clk);
         k++;
      end
      if (k >= 3000) check(10'h3FF, 10'h000);
   endtask

   task automatic wrap_up();
      if (error_cnt == 0 && samples_checked > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   // Gates never overlap and always leave a dead cycle
   always @(negedge i_clk) begin
      if (i_nrst) check({9'h000, (hs & (ls | prev_ls)) | (ls & prev_hs)},
         10'h000);
      prev_hs <= hs;
      prev_ls <= ls;
   end

   always @(posedge i_clk) begin
      cyc++;
      if (cyc == 40000) begin
         error_cnt++;
         wrap_up();
      end
   end

   // ****************************************
   // Scenarios
   // ****************************************
   task automatic t_reset();
      repeat (10) @(negedge i_clk);
      check({7'h00, hs, ls, cur}, 10'h000);
      check(trip, 10'h0BC);
      repeat (10) @(negedge i_clk);
      i_nrst = 1'b1;
      repeat (5) @(negedge i_clk);
      check({8'h00, hs, cur}, 10'h000);
   endtask

   task automatic t_start(input logic [9:0] g, input logic [9:0] exp);
      gpl = g;
      vin = 1'b0;
      sup = 1'b1;
      en = 1'b1;
      wait_on(1, 1'b1, n);
      check({9'h000, n <= 4}, 10'h001);
      wait_on(1, 1'b0, n);
      check(trip, exp);
      wait_on(0, 1'b1, n);
      wait_on(0, 1'b0, w);
      check(10'(w), 10'(bsf_pkg::DET_PULSE_CYC));
      wait_on(0, 1'b1, p);
      check(10'(w + p), 10'(bsf_pkg::DET_PERIOD_CYC));
      check({9'h000, ls}, 10'h000);
      vin = 1'b1;
      repeat (400) @(negedge i_clk);
      t1 = tgt;
      check({9'h000, t1 < bsf_pkg::REF_CODE}, 10'h001);
      repeat (400) @(negedge i_clk);
      check({9'h000, tgt > t1}, 10'h001);
      wait_on(4, 1'b1, n);
      check(tgt, bsf_pkg::REF_CODE);
      repeat (100) @(negedge i_clk);
   endtask

   task automatic t_period();
      wait_on(0, 1'b0, n);
      wait_on(0, 1'b1, n);
      wait_on(0, 1'b0, w);
      wait_on(0, 1'b1, p);
      check(10'(w + p), 10'(bsf_pkg::SW_PERIOD_CYC));
   endtask

   task automatic t_uv();
      fb = 10'h180;
      repeat (100) @(negedge i_clk);
      check({9'h000, uvt}, 10'h000);
      fb = 10'h17F;
      wait_on(2, 1'b1, n);
      check({9'h000, n <= 3}, 10'h001);
      repeat (2) @(negedge i_clk);
      check({8'h00, hs, ls}, 10'h000);
      fb = 10'h200;
      wait_on(0, 1'b1, n);
      check({9'h000, n >= HC - 3}, 10'h001);
      wait_on(4, 1'b1, n);
      repeat (100) @(negedge i_clk);
      check({9'h000, uvt}, 10'h000);
   endtask

   task automatic t_ocp();
      valley = 10'h100;
      repeat (100) @(negedge i_clk);
      check({9'h000, oct}, 10'h000);
      valley = 10'h0FF;
      wait_on(3, 1'b1, n);
      check({9'h000, n <= 70}, 10'h001);
      repeat (2) @(negedge i_clk);
      check({8'h00, hs, ls}, 10'h000);
      valley = 10'h300;
      wait_on(4, 1'b1, n);
      repeat (100) @(negedge i_clk);
   endtask

   task automatic t_disable();
      en = 1'b0;
      repeat (3) @(negedge i_clk);
      check({7'h00, hs, ls, cur}, 10'h000);
      check({8'h00, uvt, oct}, 10'h000);
      t_start(10'h007, 10'h0BC);
   endtask

   task automatic t_supply();
      sup = 1'b0;
      repeat (3) @(negedge i_clk);
      check({8'h00, hs, ls}, 10'h000);
      repeat (200) @(negedge i_clk);
      check({8'h00, hs, ls}, 10'h000);
   endtask

   initial begin
      t_reset();
      t_start(10'h100, 10'h100);
      t_period();
      t_uv();
      t_ocp();
      t_disable();
      t_supply();
      wrap_up();
   end
endmodule
